// ---- hdl/flash_cmd_regs.svh ----
// constants for the flash command decoder: widths, command codes, error register bit positions
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

`define ADDR_W         23
`define DATA_W         16
`define PART_LSB       18
`define PART_W         5
`define NUM_PART       32
`define BLK_LSB        15
`define BLK_W          8
`define NUM_BLK        256
`define CFG_W          16

`define CMD_ARRAY      8'hff
`define CMD_STATUS     8'h70
`define CMD_IDENT      8'h90
`define CMD_QUERY      8'h98
`define CMD_CLEAR      8'h50
`define CMD_PROG       8'h40
`define CMD_PROG_ALT   8'h10
`define CMD_FAST_SETUP 8'h30
`define CMD_ERASE      8'h20
`define CMD_CONFIRM    8'hd0
`define CMD_SUSPEND    8'hb0
`define CMD_LOCK_SETUP 8'h60
`define CMD_LOCK       8'h01
`define CMD_LOCK_DOWN  8'h2f
`define CMD_SET_CFG    8'h03

`define STAT_RESET     8'h80
`define STAT_W         8
`define ERR_W          4
`define ERR_ERASE      3
`define ERR_PROG       2
`define ERR_VPP        1
`define ERR_LOCK       0

`define LOCK_RESET     {`NUM_BLK{1'b1}}
`define CFG_RESET      16'h0000

`endif

// ---- hdl/flash_cmd_pkg.sv ----
// types shared by the flash command decoder
`default_nettype none
package flash_cmd_pkg;
`include "flash_cmd_regs.svh"

   typedef enum logic [1:0] {
      MODE_ARRAY,
      MODE_STATUS,
      MODE_IDENT,
      MODE_QUERY
   } rd_mode_t;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_PROG,
      PH_ERASE,
      PH_LOCK,
      PH_FAST_SETUP,
      PH_FAST_RUN
   } phase_t;

   typedef struct packed {
      logic                       wr_ok;
      logic                       cs_d;
      logic                       oe_d;
      logic [`ADDR_W-1:0]         a_cap;
      logic [`DATA_W-1:0]         d_cap;
      phase_t                     phase;
      logic                       run;
      logic                       erase_op;
      logic                       susp;
      logic [`PART_W-1:0]         busy_part;
      logic [`ERR_W-1:0]          err;
      rd_mode_t [`NUM_PART-1:0]   mode;
      logic [`NUM_BLK-1:0]        lock_on;
      logic [`NUM_BLK-1:0]        lock_dn;
      logic [`CFG_W-1:0]          cfg;
      logic                       prog_start;
      logic                       erase_start;
      logic                       fastprog_start;
      logic                       fastprog_word;
      logic                       suspend_req;
      logic                       resume_req;
      logic [`ADDR_W-1:0]         op_addr;
      logic [`DATA_W-1:0]         op_data;
      logic [`STAT_W-1:0]         status_out;
      rd_mode_t                   rd_mode;
      logic                       blk_locked;
      logic                       blk_locked_down;
   } st_t;

endpackage
`default_nettype wire

// ---- hdl/flash_command_decoder.sv ----
// command decoder of a partitioned nor flash: bus writes to per-partition modes and engine requests
//
// Behaviour
// - a write counts only while chip select and write strobe are low, output enable high
// - address and data of a write are taken at the write strobe rising edge
// - writes are decoded from the strobes alone, the burst clock plays no part
// - only one partition may program or erase at a time
// - code ffh puts the addressed partition in array read mode
// - code 70h, or any program or erase start, gives status read mode
// - code 90h puts the addressed partition in identifier mode
// - code 98h puts the addressed partition in query mode
// - error bits 5,4,3,1 are sticky; only reset or code 50h clears them
// - word program is setup 40h then a write carrying address and data
// - code 10h acts exactly as the word program setup
// - the presented status value refreshes when chip select or output enable toggles
// - 30h then d0h enters fast factory program; later writes are data only
// - erase setup not followed by confirm sets bits 5,4 and status mode
// - erase confirm erases the block addressed by the confirm write
// - a busy partition that is not suspended accepts only status read and suspend commands
// - b0h at any address suspends; bit 7 with bit 2 or 6 shows it
// - a suspension ends only by resume, engine done or hardware reset
// - d0h at any address while suspended resumes the operation
// - lock setup not followed by a lock code sets bits 5,4
// - after 60h: 01h locks, 2fh locks down, d0h unlocks unless locked down
// - 60h then 03h loads the configuration from address bits 15:0, array mode
// - after reset: array read mode and status value 80h
`timescale 1ns/1ps
`default_nettype none

module flash_command_decoder
   import flash_cmd_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 chip_sel_n,
   input  wire logic                 out_en_n,
   input  wire logic                 write_en_n,
   input  wire logic                 address_valid_n,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire logic [`DATA_W-1:0]   data_in,
   input  wire logic                 eng_done,
   input  wire logic                 eng_susp_ack,
   input  wire logic                 eng_set_lock_err,
   input  wire logic                 eng_set_vpp_err,
   input  wire logic                 eng_set_prog_err,
   input  wire logic                 eng_set_erase_err,
   output var  logic                 prog_start,
   output var  logic                 erase_start,
   output var  logic                 fastprog_start,
   output var  logic                 fastprog_word,
   output var  logic                 suspend_req,
   output var  logic                 resume_req,
   output var  logic [`ADDR_W-1:0]   op_addr,
   output var  logic [`DATA_W-1:0]   op_data,
   output var  logic [`STAT_W-1:0]   status_out,
   output var  logic [1:0]           rd_mode,
   output var  logic                 blk_locked,
   output var  logic                 blk_locked_down,
   output var  logic [`CFG_W-1:0]    cfg_out
);

   function automatic logic [`PART_W-1:0] part_of(input logic [`ADDR_W-1:0] a);
      part_of = a[`PART_LSB +: `PART_W];
   endfunction

   function automatic logic [`BLK_W-1:0] blk_of(input logic [`ADDR_W-1:0] a);
      blk_of = a[`BLK_LSB +: `BLK_W];
   endfunction

   st_t                  s_r;
   st_t                  s_nxt;
   logic                 wr_evt;
   logic                 cmd_ok;
   logic                 clr;
   logic [7:0]           code;
   logic [`PART_W-1:0]   wp;
   logic [`BLK_W-1:0]    wb;
   logic [`ERR_W-1:0]    set_err;
   logic [`STAT_W-1:0]   stat_now;

   always_comb begin
      s_nxt = s_r;
      s_nxt.prog_start     = 1'b0;
      s_nxt.erase_start    = 1'b0;
      s_nxt.fastprog_start = 1'b0;
      s_nxt.fastprog_word  = 1'b0;
      s_nxt.suspend_req    = 1'b0;
      s_nxt.resume_req     = 1'b0;
      clr     = 1'b0;
      set_err = '0;
      code    = s_r.d_cap[7:0];
      wp      = part_of(s_r.a_cap);
      wb      = blk_of(s_r.a_cap);

      // strobe qualification, sampled every cycle; no burst clock involved
      s_nxt.wr_ok = ~chip_sel_n & ~write_en_n & out_en_n;
      if (s_nxt.wr_ok) begin
         s_nxt.d_cap = data_in;
         if (!address_valid_n) begin
            s_nxt.a_cap = addr;
         end
      end
      // the write is taken when the strobe rises after a qualified low phase
      wr_evt = s_r.wr_ok & write_en_n;

      // a busy, running partition only hears status read and suspend
      cmd_ok = !(s_r.run && !s_r.susp && wp == s_r.busy_part)
               || code == `CMD_STATUS || code == `CMD_SUSPEND;

      // engine handshakes
      if (eng_susp_ack && s_r.run) begin
         s_nxt.susp = 1'b1;
      end
      if (eng_done) begin
         s_nxt.run  = 1'b0;
         s_nxt.susp = 1'b0;
         if (s_r.phase == PH_FAST_RUN) begin
            s_nxt.phase = PH_IDLE;
         end
      end

      if (wr_evt) begin
         case (s_r.phase)
            PH_FAST_RUN: begin
               // every write is program data; commands are not decoded
               s_nxt.fastprog_word = 1'b1;
               s_nxt.op_addr       = s_r.a_cap;
               s_nxt.op_data       = s_r.d_cap;
            end
            PH_PROG: begin
               s_nxt.phase    = PH_IDLE;
               s_nxt.mode[wp] = MODE_STATUS;
               if (s_r.lock_on[wb]) begin
                  set_err[`ERR_LOCK] = 1'b1;
                  set_err[`ERR_PROG] = 1'b1;
               end else begin
                  s_nxt.prog_start = 1'b1;
                  s_nxt.op_addr    = s_r.a_cap;
                  s_nxt.op_data    = s_r.d_cap;
                  s_nxt.run        = 1'b1;
                  s_nxt.erase_op   = 1'b0;
                  s_nxt.busy_part  = wp;
               end
            end
            PH_ERASE: begin
               s_nxt.phase    = PH_IDLE;
               s_nxt.mode[wp] = MODE_STATUS;
               if (code != `CMD_CONFIRM) begin
                  set_err[`ERR_ERASE] = 1'b1;
                  set_err[`ERR_PROG]  = 1'b1;
               end else if (s_r.lock_on[wb]) begin
                  set_err[`ERR_LOCK]  = 1'b1;
                  set_err[`ERR_ERASE] = 1'b1;
               end else begin
                  // block comes from the confirm write, not the setup write
                  s_nxt.erase_start = 1'b1;
                  s_nxt.op_addr     = s_r.a_cap;
                  s_nxt.op_data     = s_r.d_cap;
                  s_nxt.run         = 1'b1;
                  s_nxt.erase_op    = 1'b1;
                  s_nxt.busy_part   = wp;
               end
            end
            PH_LOCK: begin
               s_nxt.phase = PH_IDLE;
               case (code)
                  `CMD_LOCK: begin
                     s_nxt.lock_on[wb] = 1'b1;
                  end
                  `CMD_LOCK_DOWN: begin
                     s_nxt.lock_on[wb] = 1'b1;
                     s_nxt.lock_dn[wb] = 1'b1;
                  end
                  `CMD_CONFIRM: begin
                     if (!s_r.lock_dn[wb]) begin
                        s_nxt.lock_on[wb] = 1'b0;
                     end
                  end
                  `CMD_SET_CFG: begin
                     s_nxt.cfg      = s_r.a_cap[`CFG_W-1:0];
                     s_nxt.mode[wp] = MODE_ARRAY;
                  end
                  default: begin
                     set_err[`ERR_ERASE] = 1'b1;
                     set_err[`ERR_PROG]  = 1'b1;
                  end
               endcase
            end
            PH_FAST_SETUP: begin
               s_nxt.mode[wp] = MODE_STATUS;
               if (code == `CMD_CONFIRM) begin
                  s_nxt.phase          = PH_FAST_RUN;
                  s_nxt.fastprog_start = 1'b1;
                  s_nxt.op_addr        = s_r.a_cap;
                  s_nxt.op_data        = s_r.d_cap;
                  s_nxt.run            = 1'b1;
                  s_nxt.erase_op       = 1'b0;
                  s_nxt.busy_part      = wp;
               end else begin
                  s_nxt.phase         = PH_IDLE;
                  set_err[`ERR_ERASE] = 1'b1;
                  set_err[`ERR_PROG]  = 1'b1;
               end
            end
            default: begin
               if (cmd_ok) begin
                  case (code)
                     `CMD_ARRAY:  s_nxt.mode[wp] = MODE_ARRAY;
                     `CMD_STATUS: s_nxt.mode[wp] = MODE_STATUS;
                     `CMD_IDENT:  s_nxt.mode[wp] = MODE_IDENT;
                     `CMD_QUERY:  s_nxt.mode[wp] = MODE_QUERY;
                     `CMD_CLEAR:  clr = 1'b1;
                     `CMD_PROG, `CMD_PROG_ALT: begin
                        if (!s_r.run) begin
                           s_nxt.phase = PH_PROG;
                        end
                     end
                     `CMD_ERASE: begin
                        if (!s_r.run) begin
                           s_nxt.phase = PH_ERASE;
                        end
                     end
                     `CMD_FAST_SETUP: begin
                        if (!s_r.run) begin
                           s_nxt.phase = PH_FAST_SETUP;
                        end
                     end
                     `CMD_LOCK_SETUP: s_nxt.phase = PH_LOCK;
                     `CMD_SUSPEND: begin
                        if (s_r.run && !s_r.susp) begin
                           s_nxt.suspend_req = 1'b1;
                        end
                     end
                     `CMD_CONFIRM: begin
                        if (s_r.susp) begin
                           s_nxt.resume_req = 1'b1;
                           s_nxt.susp       = 1'b0;
                        end
                     end
                     default: ;
                  endcase
               end
            end
         endcase
      end

      set_err[`ERR_LOCK]  = set_err[`ERR_LOCK]  | eng_set_lock_err;
      set_err[`ERR_VPP]   = set_err[`ERR_VPP]   | eng_set_vpp_err;
      set_err[`ERR_PROG]  = set_err[`ERR_PROG]  | eng_set_prog_err;
      set_err[`ERR_ERASE] = set_err[`ERR_ERASE] | eng_set_erase_err;
      // a set arriving with the clear command survives it
      s_nxt.err = (s_r.err & ~{`ERR_W{clr}}) | set_err;

      stat_now = {~s_r.run | s_r.susp, s_r.susp & s_r.erase_op,
                  s_r.err[`ERR_ERASE], s_r.err[`ERR_PROG], s_r.err[`ERR_VPP],
                  s_r.susp & ~s_r.erase_op, s_r.err[`ERR_LOCK], 1'b0};
      s_nxt.cs_d = chip_sel_n;
      s_nxt.oe_d = out_en_n;
      if (chip_sel_n != s_r.cs_d || out_en_n != s_r.oe_d) begin
         s_nxt.status_out = stat_now;
      end

      s_nxt.rd_mode         = s_r.mode[part_of(addr)];
      s_nxt.blk_locked      = s_r.lock_on[blk_of(addr)];
      s_nxt.blk_locked_down = s_r.lock_dn[blk_of(addr)];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r            <= '0;
         s_r.cs_d       <= 1'b1;
         s_r.oe_d       <= 1'b1;
         s_r.status_out <= `STAT_RESET;
         s_r.lock_on    <= `LOCK_RESET;
         s_r.cfg        <= `CFG_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prog_start      = s_r.prog_start;
   assign erase_start     = s_r.erase_start;
   assign fastprog_start  = s_r.fastprog_start;
   assign fastprog_word   = s_r.fastprog_word;
   assign suspend_req     = s_r.suspend_req;
   assign resume_req      = s_r.resume_req;
   assign op_addr         = s_r.op_addr;
   assign op_data         = s_r.op_data;
   assign status_out      = s_r.status_out;
   assign rd_mode         = s_r.rd_mode;
   assign blk_locked      = s_r.blk_locked;
   assign blk_locked_down = s_r.blk_locked_down;
   assign cfg_out         = s_r.cfg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_idle_cmd(logic [7:0] c);
      wr_evt && s_r.phase == PH_IDLE && cmd_ok && code == c;
   endsequence

   sequence s_second_write(phase_t ph);
      wr_evt && s_r.phase == ph;
   endsequence

   chk_write_qual: assert property (wr_evt |-> $past(~chip_sel_n & ~write_en_n & out_en_n))
      else $error("write taken without a qualified strobe phase");
   chk_addr_capture: assert property (s_second_write(PH_PROG) ##0 !s_r.lock_on[wb]
      |=> prog_start && op_addr == $past(s_r.a_cap) && op_data == $past(s_r.d_cap))
      else $error("program did not carry the captured address and data");
   chk_array_mode: assert property (s_idle_cmd(`CMD_ARRAY)
      |=> s_r.mode[$past(wp)] == MODE_ARRAY)
      else $error("array command did not set array mode");
   chk_status_mode: assert property ((prog_start || erase_start)
      |-> s_r.mode[s_r.busy_part] == MODE_STATUS)
      else $error("program or erase left partition out of status mode");
   chk_ident_mode: assert property (s_idle_cmd(`CMD_IDENT)
      |=> s_r.mode[$past(wp)] == MODE_IDENT)
      else $error("identifier command not applied");
   chk_query_mode: assert property (s_idle_cmd(`CMD_QUERY)
      |=> s_r.mode[$past(wp)] == MODE_QUERY)
      else $error("query command not applied");
   chk_sticky_err: assert property (!clr |=> (s_r.err & $past(s_r.err)) == $past(s_r.err))
      else $error("sticky error bit cleared without clear command");
   chk_prog_alias: assert property (s_idle_cmd(`CMD_PROG_ALT) ##0 !s_r.run
      |=> s_r.phase == PH_PROG)
      else $error("alternate program setup not accepted");
   chk_status_refresh: assert property (status_out != $past(status_out)
      |-> $past(chip_sel_n) != $past(s_r.cs_d) || $past(out_en_n) != $past(s_r.oe_d))
      else $error("status value changed without a select toggle");
   chk_fast_data: assert property (s_second_write(PH_FAST_RUN) ##0 !eng_done
      |=> fastprog_word && !prog_start && !erase_start && s_r.phase == PH_FAST_RUN)
      else $error("fast program write was decoded as a command");
   chk_erase_seq_err: assert property (s_second_write(PH_ERASE) ##0 code != `CMD_CONFIRM
      |=> s_r.err[`ERR_ERASE] && s_r.err[`ERR_PROG] && s_r.mode[$past(wp)] == MODE_STATUS)
      else $error("bad erase confirm not flagged");
   chk_busy_filter: assert property (wr_evt && s_r.phase == PH_IDLE && !cmd_ok
      |=> $stable(s_r.mode) && s_r.phase == PH_IDLE)
      else $error("busy partition accepted a forbidden command");
   chk_single_op: assert property ((prog_start || erase_start || fastprog_start)
      |-> !$past(s_r.run))
      else $error("second operation started while one runs");
   chk_suspend_req: assert property (s_idle_cmd(`CMD_SUSPEND) ##0 (s_r.run && !s_r.susp)
      |=> suspend_req)
      else $error("suspend command not forwarded");
   chk_susp_hold: assert property (s_r.susp && !eng_done
      && !(wr_evt && s_r.phase == PH_IDLE && code == `CMD_CONFIRM)
      |=> s_r.susp)
      else $error("suspension ended without resume");
   chk_resume: assert property (s_idle_cmd(`CMD_CONFIRM) ##0 s_r.susp
      |=> resume_req ##1 !resume_req)
      else $error("resume not issued as a single pulse");
   chk_lock_seq_err: assert property (s_second_write(PH_LOCK) ##0 (code != `CMD_LOCK
      && code != `CMD_LOCK_DOWN && code != `CMD_CONFIRM && code != `CMD_SET_CFG)
      |=> s_r.err[`ERR_ERASE] && s_r.err[`ERR_PROG])
      else $error("bad lock second cycle not flagged");
   chk_lockdown_held: assert property ((~s_r.lock_dn | s_r.lock_on) == `LOCK_RESET)
      else $error("locked-down block became unlocked");
   chk_cfg_load: assert property (s_second_write(PH_LOCK) ##0 code == `CMD_SET_CFG
      |=> cfg_out == $past(s_r.a_cap[`CFG_W-1:0]) && s_r.mode[$past(wp)] == MODE_ARRAY)
      else $error("configuration load failed");

endmodule // flash_command_decoder
`default_nettype wire

// ---- test/engine_model.sv ----
// behavioural algorithm engine that answers the decoder's start, suspend and resume requests
`timescale 1ns/1ps
`default_nettype none
module engine_model #(
   parameter int BUSY = 40
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic suspend_req,
   input  wire logic resume_req,
   input  wire logic fail,
   output var  logic done,
   output var  logic susp_ack,
   output var  logic prog_err
);
   int   cnt;
   logic susp;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt      <= 0;
         susp     <= 1'b0;
         done     <= 1'b0;
         susp_ack <= 1'b0;
         prog_err <= 1'b0;
      end else begin
         done     <= 1'b0;
         susp_ack <= 1'b0;
         prog_err <= 1'b0;
         if (start) begin
            cnt  <= BUSY;
            susp <= 1'b0;
         end else if (suspend_req) begin
            susp     <= 1'b1;
            susp_ack <= 1'b1;
         end else if (resume_req) begin
            susp <= 1'b0;
         end else if (cnt > 0 && !susp) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               done     <= 1'b1;
               prog_err <= fail;
            end
         end
      end
   end
endmodule // engine_model
`default_nettype wire

// ---- test/flash_command_decoder_bench.sv ----
// self-checking bench of the flash command decoder
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_command_decoder_bench;
   import flash_cmd_pkg::*;
   localparam logic [22:0] B1 = 23'h048000;
   localparam logic [22:0] B2 = 23'h050000;
   logic mclk, rst_n, chip_sel_n, out_en_n, write_en_n, address_valid_n, fail;
   logic eng_done, eng_susp_ack, eng_set_prog_err;
   logic prog_start, erase_start, fastprog_start, fastprog_word, suspend_req, resume_req;
   logic blk_locked, blk_locked_down;
   logic [1:0] rd_mode;
   logic [`ADDR_W-1:0] addr, op_addr;
   logic [`DATA_W-1:0] data_in, op_data, cfg_out;
   logic [`STAT_W-1:0] status_out;
   int failures, n_checks, cyc, n_prog, n_erase, n_fs, n_fw, n_sreq, n_rreq;
   logic [7:0] rcode[4] = '{8'hff, 8'h70, 8'h90, 8'h98};
   logic [7:0] lcode[5] = '{8'hd0, 8'h01, 8'hd0, 8'h2f, 8'hd0};
   logic lexp[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

   flash_command_decoder i_dut (.mclk, .rst_n, .chip_sel_n, .out_en_n, .write_en_n,
      .address_valid_n, .addr, .data_in, .eng_done, .eng_susp_ack,
      .eng_set_lock_err(eng_set_prog_err), .eng_set_vpp_err(eng_set_prog_err),
      .eng_set_prog_err, .eng_set_erase_err(eng_set_prog_err), .prog_start,
      .erase_start, .fastprog_start, .fastprog_word, .suspend_req, .resume_req, .op_addr,
      .op_data, .status_out, .rd_mode, .blk_locked, .blk_locked_down, .cfg_out);
   engine_model i_eng (.mclk, .rst_n, .start(prog_start | erase_start | fastprog_start),
      .suspend_req, .resume_req, .fail, .done(eng_done), .susp_ack(eng_susp_ack),
      .prog_err(eng_set_prog_err));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      n_prog += int'(prog_start === 1'b1);
      n_erase += int'(erase_start === 1'b1);
      n_fs += int'(fastprog_start === 1'b1);
      n_fw += int'(fastprog_word === 1'b1);
      n_sreq += int'(suspend_req === 1'b1);
      n_rreq += int'(resume_req === 1'b1);
      cyc++;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test;
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one write cycle; oe_n low makes it a cycle the decoder must not take
   task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic oe = 1'b1);
      @(posedge mclk);
      #1;
      chip_sel_n = 1'b0;
      write_en_n = 1'b0;
      out_en_n = oe;
      address_valid_n = 1'b0;
      addr = a;
      data_in = d;
      repeat (2) @(posedge mclk);
      #1;
      write_en_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chip_sel_n = 1'b1;
      out_en_n = 1'b1;
      address_valid_n = 1'b1;
   endtask
   // read cycle: the output enable toggle refreshes the presented status
   task automatic rd(input logic [22:0] a);
      @(posedge mclk);
      #1;
      chip_sel_n = 1'b0;
      out_en_n = 1'b0;
      addr = a;
      repeat (2) @(posedge mclk);
      #1;
      chip_sel_n = 1'b1;
      out_en_n = 1'b1;
   endtask
   task automatic idle;
      for (int i = 0; i < 300 && eng_done !== 1'b1; i++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      #1;
   endtask

   initial begin
      {chip_sel_n, out_en_n, write_en_n, address_valid_n} = 4'hf;
      {fail, addr, data_in, rst_n} = '0;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      rd(B1);
      chk(rd_mode, 0);
      chk(status_out, 8'h80);
      chk({blk_locked, blk_locked_down, cfg_out}, 18'h20000);
      for (int i = 0; i < 4; i++) begin
         wr(B1, {8'h00, rcode[i]});
         rd(B1);
         chk(rd_mode, i);
      end
      rd(23'h080000);
      chk(rd_mode, 0);
      wr(B1, 16'h00ff, 1'b0);
      rd(B1);
      chk(rd_mode, 3);
      for (int i = 0; i < 5; i++) begin
         wr(B1, 16'h0060);
         wr(B1, {8'h00, lcode[i]});
         rd(B1);
         chk(blk_locked, lexp[i]);
      end
      chk(blk_locked_down, 1);
      wr(B2, 16'h0060);
      wr(B2, 16'h00ff);
      rd(B2);
      chk(status_out, 8'hb0);
      wr(B2, 16'h0050);
      rd(B2);
      chk(status_out, 8'h80);
      wr(B2, 16'h0060);
      wr(B2, 16'h00d0);
      wr(23'h001234, 16'h0060);
      wr(23'h001234, 16'h0003);
      rd(23'h001234);
      chk({cfg_out, rd_mode}, 18'h048d0);
      wr(23'h0, 16'h0040);
      wr(23'h0, 16'h5555);
      rd(23'h0);
      chk({n_prog[7:0], status_out}, 16'h0092);
      wr(B2, 16'h0050);
      fail = 1'b1;
      wr(B2 + 23'd5, 16'h0010);
      wr(B2 + 23'd5, 16'habcd);
      chk(n_prog, 1);
      chk({op_addr, op_data}, {B2 + 23'd5, 16'habcd});
      rd(B2);
      chk({rd_mode, status_out}, 10'h100);
      wr(B2, 16'h0090);
      wr(23'h080000, 16'h0040);
      rd(B2);
      chk({n_prog[1:0], rd_mode}, 4'h5);
      idle();
      fail = 1'b0;
      chk(status_out, 8'h00);
      wr(B2, 16'h00ff);
      rd(B2);
      chk(status_out, 8'hba);
      wr(B2, 16'h0050);
      wr(B1, 16'h0020);
      wr(B2, 16'h00d0);
      chk({n_erase[7:0], 1'b0, op_addr}, {8'h01, 1'b0, B2});
      wr(23'h0, 16'h00b0);
      repeat (60) @(posedge mclk);
      rd(B2);
      chk({n_sreq[7:0], status_out}, 16'h01c0);
      wr(23'h0, 16'h00d0);
      chk(n_rreq, 1);
      idle();
      rd(B2);
      chk(status_out, 8'h80);
      wr(B1, 16'h0020);
      wr(B1, 16'h00ff);
      rd(B1);
      chk({rd_mode, status_out}, 10'h1b0);
      wr(B1, 16'h0050);
      wr(B2, 16'h0030);
      wr(B2, 16'h00d0);
      wr(B2 + 23'd1, 16'h1111);
      wr(B2 + 23'd2, 16'h0070);
      chk({n_fs[3:0], n_fw[3:0]}, 8'h12);
      chk(op_data, 16'h0070);
      idle();
      stop_test();
   end
endmodule // flash_command_decoder_bench
`default_nettype wire
